/* core/pmt_pkg.sv */
/*
 * pmt_pkg: constants for the 10/100 line datapath timing block: clock rate,
 * line bit times, pipeline latencies, reset and link pulse timing, codes.
 * Assumes a single 40 MHz system clock; every count is in those cycles.
 */
package pmt_pkg;
	// system clock
	localparam int CLK_PERIOD_NS = 25; // 40 MHz
	localparam int CLK_KHZ = 40000; // cycles per millisecond
	localparam int SYNC_CYC = 2; // two-flop pin synchroniser depth
	// line bit times
	localparam int BIT10_NS = 100;
	localparam int BIT100_NS = 10;
	localparam int BIT10_CYC = BIT10_NS / CLK_PERIOD_NS;
	// receive latency ceilings in bit times, longest times round down
	localparam int RX10_MAX_BITS = 7;
	localparam int RX100_MAX_BITS = 17;
	localparam int RX10_LAT_CYC = RX10_MAX_BITS * BIT10_NS / CLK_PERIOD_NS;
	localparam int RX100_LAT_CYC = RX100_MAX_BITS * BIT100_NS / CLK_PERIOD_NS;
	// stage index inside the receive pipeline (sync and output flop removed)
	localparam int RX10_TAP = RX10_LAT_CYC - SYNC_CYC - 1;
	localparam int RX100_TAP = RX100_LAT_CYC - SYNC_CYC - 1;
	localparam int RX_PIPE_DEPTH = RX10_TAP;
	// transmit latency ceilings in bit times
	localparam int TX10_MAX_BITS = 2;
	localparam int TX100_MAX_BITS = 3;
	localparam int TX10_LAT_CYC = TX10_MAX_BITS * BIT10_NS / CLK_PERIOD_NS;
	localparam int TX100_LAT_CYC = TX100_MAX_BITS * BIT100_NS / CLK_PERIOD_NS;
	// carrier sense during half-duplex transmit
	localparam int CRS_ON_MAX_BITS = 2;
	localparam int CRS_OFF_TYP_BITS = 2;
	localparam int CRS_OFF_MAX_BITS = 4;
	localparam int CRS_ON_CYC = CRS_ON_MAX_BITS * BIT10_CYC;
	localparam int CRS_OFF_CYC = CRS_OFF_MAX_BITS * BIT10_CYC;
	localparam int CRS_HOLD_CYC = CRS_OFF_TYP_BITS * BIT10_CYC - SYNC_CYC - 1;
	// reset sequencing
	localparam int LONG_W = 21; // width of the long counters
	localparam int POR_MIN_MS = 40;
	localparam int TXCLK_TYP_MS = 35;
	localparam int RST_MIN_NS = 200;
	localparam int ISOLATE_NS = 60;
	localparam int POR_CYC = POR_MIN_MS * CLK_KHZ;
	localparam int TXCLK_CYC = TXCLK_TYP_MS * CLK_KHZ;
	localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ISOLATE_CYC = ISOLATE_NS / CLK_PERIOD_NS;
	// normal link pulses
	localparam int NLP_WIDTH_NS = 100;
	localparam int NLP_PERIOD_MS = 20;
	localparam int NLP_MIN_MS = 8;
	localparam int NLP_WIDTH_CYC = NLP_WIDTH_NS / CLK_PERIOD_NS;
	localparam int NLP_PERIOD_CYC = NLP_PERIOD_MS * CLK_KHZ;
	// 100 Mb/s code groups
	localparam logic [4:0] CODE_J = 5'h18;
	localparam logic [4:0] CODE_K = 5'h11;
	localparam logic [4:0] CODE_T = 5'h0d;
	localparam logic [4:0] CODE_R = 5'h07;
	localparam logic [4:0] CODE_IDLE = 5'h1f;
	localparam logic [4:0] CODE_4B5B [16] = '{5'h1e, 5'h09, 5'h14, 5'h15,
		5'h0a, 5'h0b, 5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17,
		5'h1a, 5'h1b, 5'h1c, 5'h1d};
	// 100 Mb/s transmit framing states
	typedef enum logic [2:0] {
		PMT_TX_IDLE, PMT_TX_J, PMT_TX_K, PMT_TX_DATA, PMT_TX_T, PMT_TX_R
	} pmt_tx_state_t;
endpackage : pmt_pkg

/* core/pmt_datapath.sv */
/*
 * pmt_datapath: timing model of a 10/100 transceiver datapath between the
 * nibble bus of the attached MAC and the twisted-pair line, with reset
 * sequencing, transmit clock gating and 10 Mb/s link pulses.
 * Assumes all pins are asynchronous to sys_clk_in and are synchronised here;
 * the line side is abstracted to nibbles, code groups and one serial pin.
 */
`timescale 1ns/1ps
// Summary of operation
// - 10M receive nibble out within 7 bits
// - 10M first transmit bit within 2 bits
// - 100M /J/ on line within 3 bits
// - 10M half-duplex CRS rises within 2 bits of TXEN
// - CRS falls within 4 bits, typically 2
// - 100M receive /J/ out within 17 bits
// - power-on reset completes after 40 ms
// - reset pin low isolates device within 60 ns
// - transmit clock valid 35 ms after release
// - link pulses are 100 ns wide
// - idle link pulses spaced 20 ms apart
module pmt_datapath #(
	parameter logic [pmt_pkg::LONG_W-1:0] POR_CYC_P =
		pmt_pkg::LONG_W'(pmt_pkg::POR_CYC),
	parameter logic [pmt_pkg::LONG_W-1:0] TXCLK_CYC_P =
		pmt_pkg::LONG_W'(pmt_pkg::TXCLK_CYC),
	parameter logic [pmt_pkg::LONG_W-1:0] NLP_PERIOD_CYC_P =
		pmt_pkg::LONG_W'(pmt_pkg::NLP_PERIOD_CYC)
) (
	// clock, reset, enable
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	// configuration pins
	input wire logic speed_100_in,
	input wire logic full_duplex_in,
	input wire logic hw_reset_n_in,
	// media independent side
	input wire logic mii_ref_clk_in,
	input wire logic tx_en_in,
	input wire logic [3:0] txd_in,
	output logic tx_clk_out,
	output logic [3:0] rxd_out,
	output logic rx_dv_out,
	output logic crs_out,
	// line side
	input wire logic [3:0] line_receive_pair_in,
	input wire logic line_receive_act_in,
	output logic line_transmit_pos_out,
	output logic [4:0] line_transmit_code_out,
	// status
	output logic isolated_out,
	output logic ready_out
);
	import pmt_pkg::*;

	localparam int SYNC_W = 14;
	localparam int RX10_D = RX10_LAT_CYC;
	localparam int RX100_D = RX100_LAT_CYC;
	localparam int ISO_D = ISOLATE_CYC; // isolation bound in cycles
	localparam int CRS_ON_D = CRS_ON_CYC;
	localparam int CRS_OFF_D = CRS_OFF_CYC;
	localparam int NLP_W_D = NLP_WIDTH_CYC;

	logic [SYNC_W-1:0] pin_meta; // first synchroniser stage
	logic [SYNC_W-1:0] pin_sync; // second stage, the only one the logic reads
	logic spd100; // 100 Mb/s selected
	logic fdx; // full duplex selected
	logic rst_pin_n; // synchronised reset pin
	logic ref_clk; // synchronised transmit reference clock
	logic ref_d; // previous reference clock level
	logic tx_en; // synchronised transmit enable
	logic [3:0] txd; // synchronised transmit nibble
	logic rx_act; // synchronised line activity
	logic [3:0] rx_nib; // synchronised line nibble
	logic sample; // rising edge of the reference clock
	logic [LONG_W-1:0] init_cnt; // remaining initialisation time
	logic [3:0] low_cnt; // reset pin low time, saturating
	logic ready; // initialisation complete and not isolated
	logic [4:0] rx_pipe [RX_PIPE_DEPTH]; // receive delay line
	logic [4:0] rx_tap; // selected stage
	logic [3:0] tx_shift; // 10M serialiser
	logic [2:0] tx_bits; // bits left in the serialiser
	logic [1:0] bit_cnt; // cycles within one 10M bit
	pmt_tx_state_t tx_state; // 100M framing state
	logic [2:0] crs_cnt; // carrier hold after transmit ends
	logic tx_en_d; // previous synchronised enable
	logic [LONG_W-1:0] nlp_cnt; // spacing between link pulses
	logic [2:0] nlp_width; // cycles left in current pulse
	logic nlp_on; // pulse on the line

	assign {spd100, fdx, rst_pin_n, ref_clk, tx_en, txd, rx_act, rx_nib} =
		pin_sync;
	assign sample = ref_clk & ~ref_d;
	assign ready = (init_cnt == '0) & rst_pin_n;

	// two-flop synchroniser for every pin
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else if (ce_in) begin
			pin_meta <= {speed_100_in, full_duplex_in, hw_reset_n_in,
				mii_ref_clk_in, tx_en_in, txd_in, line_receive_act_in,
				line_receive_pair_in};
			pin_sync <= pin_meta;
		end
	end

	// reference clock edge finder
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			ref_d <= 1'b0;
		end else if (ce_in) begin
			ref_d <= ref_clk;
		end
	end

	// reset pin low time, for pulse width qualification
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			low_cnt <= '0;
		end else if (ce_in) begin
			if (rst_pin_n) begin
				low_cnt <= '0;
			end else if (low_cnt != 4'(RST_MIN_CYC)) begin
				low_cnt <= low_cnt + 4'h1;
			end
		end
	end

	// power-on and pin reset initialisation counter
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			init_cnt <= POR_CYC_P;
		end else if (ce_in) begin
			if (!rst_pin_n && low_cnt == 4'(RST_MIN_CYC)) begin
				init_cnt <= TXCLK_CYC_P;
			end else if (init_cnt != '0) begin
				init_cnt <= init_cnt - 1'b1;
			end
		end
	end

	// isolation follows the synchronised pin, one cycle after it falls
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			isolated_out <= 1'b1;
			ready_out <= 1'b0;
			tx_clk_out <= 1'b0;
		end else if (ce_in) begin
			isolated_out <= ~rst_pin_n;
			ready_out <= ready;
			tx_clk_out <= ref_clk & ready;
		end
	end

	// receive delay line, one stage per cycle
	generate
		for (genvar i = 0; i < RX_PIPE_DEPTH; i++) begin : g_rx
			always_ff @(posedge sys_clk_in) begin
				if (rst_in) begin
					rx_pipe[i] <= '0;
				end else if (ce_in) begin
					if (i == 0) begin
						rx_pipe[i] <= {rx_act, rx_nib};
					end else begin
						rx_pipe[i] <= rx_pipe[i-1];
					end
				end
			end
		end
	endgenerate

	// tap chosen by line rate so latency is in line bit times
	always_comb begin
		if (spd100) begin
			rx_tap = rx_pipe[RX100_TAP-1];
		end else begin
			rx_tap = rx_pipe[RX10_TAP-1];
		end
	end

	// receive outputs toward the MAC
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			rx_dv_out <= 1'b0;
			rxd_out <= '0;
		end else if (ce_in) begin
			rx_dv_out <= rx_tap[4] & ready;
			rxd_out <= ready ? rx_tap[3:0] : 4'h0;
		end
	end

	// 10M serialiser: nibble loaded on the sample edge, LSB first
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			tx_shift <= '0;
			tx_bits <= '0;
			bit_cnt <= '0;
		end else if (ce_in) begin
			if (sample && tx_en && !spd100 && ready) begin
				tx_shift <= txd;
				tx_bits <= 3'h4;
				bit_cnt <= '0;
			end else if (tx_bits != '0) begin
				bit_cnt <= bit_cnt + 2'h1;
				if (bit_cnt == 2'(BIT10_CYC - 1)) begin
					tx_shift <= {1'b0, tx_shift[3:1]};
					tx_bits <= tx_bits - 3'h1;
				end
			end
		end
	end

	// 100M framing: /J/ /K/, data, then /T/ /R/ and idle
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			tx_state <= PMT_TX_IDLE;
			line_transmit_code_out <= CODE_IDLE;
		end else if (ce_in) begin
			if (!spd100 || !ready) begin
				tx_state <= PMT_TX_IDLE;
				line_transmit_code_out <= CODE_IDLE;
			end else if (sample) begin
				case (tx_state)
					PMT_TX_IDLE: begin
						if (tx_en) begin
							tx_state <= PMT_TX_J;
							line_transmit_code_out <= CODE_J;
						end
					end
					PMT_TX_J: begin
						tx_state <= PMT_TX_K;
						line_transmit_code_out <= CODE_K;
					end
					PMT_TX_K, PMT_TX_DATA: begin
						if (tx_en) begin
							tx_state <= PMT_TX_DATA;
							line_transmit_code_out <= CODE_4B5B[txd];
						end else begin
							tx_state <= PMT_TX_T;
							line_transmit_code_out <= CODE_T;
						end
					end
					PMT_TX_T: begin
						tx_state <= PMT_TX_R;
						line_transmit_code_out <= CODE_R;
					end
					PMT_TX_R: begin
						tx_state <= PMT_TX_IDLE;
						line_transmit_code_out <= CODE_IDLE;
					end
					default: begin
						tx_state <= PMT_TX_IDLE;
						line_transmit_code_out <= CODE_IDLE;
					end
				endcase
			end
		end
	end

	// carrier sense, half duplex only: own transmit at 10M, or line activity
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			crs_out <= 1'b0;
			crs_cnt <= '0;
			tx_en_d <= 1'b0;
		end else if (ce_in) begin
			tx_en_d <= tx_en;
			if (tx_en && !spd100 && !fdx && ready) begin
				crs_out <= 1'b1;
				crs_cnt <= 3'(CRS_HOLD_CYC);
			end else if (crs_cnt != '0) begin
				crs_cnt <= crs_cnt - 3'h1;
				crs_out <= 1'b1;
			end else begin
				crs_out <= rx_act & ready & ~fdx;
			end
		end
	end

	// link pulse spacing and width while the 10M line is idle
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			nlp_cnt <= '0;
			nlp_width <= '0;
			nlp_on <= 1'b0;
		end else if (ce_in) begin
			if (spd100 || !ready || tx_en || tx_bits != '0) begin
				nlp_cnt <= '0;
				nlp_width <= '0;
				nlp_on <= 1'b0;
			end else if (nlp_width != '0) begin
				nlp_width <= nlp_width - 3'h1;
				nlp_on <= (nlp_width != 3'h1);
			end else if (nlp_cnt == NLP_PERIOD_CYC_P - 1'b1) begin
				nlp_cnt <= '0;
				nlp_width <= 3'(NLP_WIDTH_CYC);
				nlp_on <= 1'b1;
			end else begin
				nlp_cnt <= nlp_cnt + 1'b1;
			end
		end
	end

	// serial line pin: data bit, otherwise the idle link pulse
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			line_transmit_pos_out <= 1'b0;
		end else if (ce_in) begin
			line_transmit_pos_out <= (tx_bits != '0) ? tx_shift[0] : nlp_on;
		end
	end

	// checks, assuming ce_in high and rate pins stable around the event
	a_rx10_latency: assert property (@(posedge sys_clk_in)
		disable iff (rst_in || !ce_in)
		($rose(pin_meta[4]) && !spd100 && ready)[*1] ##0 1'b1
		|-> ##(RX10_D - 1) (rx_dv_out || !ready || spd100))
		else $error("10M receive nibble late");
	a_rx100_latency: assert property (@(posedge sys_clk_in)
		disable iff (rst_in || !ce_in)
		($rose(pin_meta[4]) && spd100 && ready)
		|-> ##(RX100_D - 1) (rx_dv_out || !ready || !spd100))
		else $error("100M receive code late");
	a_tx10_first_bit: assert property (@(posedge sys_clk_in)
		disable iff (rst_in || !ce_in)
		(sample && tx_en && !spd100 && ready)
		|-> ##2 (line_transmit_pos_out == $past(txd[0], 2)))
		else $error("10M first bit late");
	a_tx100_j_code: assert property (@(posedge sys_clk_in)
		disable iff (rst_in || !ce_in)
		(sample && tx_en && spd100 && ready && tx_state == PMT_TX_IDLE)
		|=> line_transmit_code_out == CODE_J)
		else $error("100M start code late");
	a_crs_on: assert property (@(posedge sys_clk_in)
		disable iff (rst_in || !ce_in)
		($rose(tx_en_in) && !spd100 && !fdx && ready)
		|-> ##[1:CRS_ON_D] crs_out)
		else $error("carrier sense rise late");
	a_crs_off: assert property (@(posedge sys_clk_in)
		disable iff (rst_in || !ce_in)
		($fell(tx_en) && !spd100 && !fdx && !rx_act && !tx_en_in)
		|-> crs_out [*5] ##[1:CRS_OFF_D] !crs_out)
		else $error("carrier sense hold wrong");
	a_nlp_width: assert property (@(posedge sys_clk_in)
		disable iff (rst_in || !ce_in)
		($rose(nlp_on) && !spd100 && ready && !tx_en)
		|-> nlp_on [*4] ##1 !nlp_on)
		else $error("link pulse width wrong");
	a_nlp_spacing: assert property (@(posedge sys_clk_in)
		disable iff (rst_in || !ce_in)
		$rose(nlp_on) |-> (nlp_cnt == '0 && $past(nlp_cnt) != '0))
		else $error("link pulse early");
	a_isolate: assert property (@(posedge sys_clk_in)
		disable iff (rst_in || !ce_in)
		$fell(pin_meta[11]) |-> ##[1:ISO_D] isolated_out)
		else $error("isolation late");
	a_reset_qual: assert property (@(posedge sys_clk_in)
		disable iff (rst_in || !ce_in)
		(!rst_pin_n && low_cnt == 4'(RST_MIN_CYC))
		|=> init_cnt == TXCLK_CYC_P)
		else $error("qualified reset not honoured");
endmodule : pmt_datapath

/* test/pmt_mac_model.sv */
/* pmt_mac_model: MAC side of the nibble bus, with a free running transmit
 * reference clock and a nibble driver. Assumes the bench calls put(). */
`timescale 1ns/1ps
module pmt_mac_model (
	// nibble bus towards the device
	output logic ref_clk_out,
	output logic tx_en_out,
	output logic [3:0] txd_out
);
	int half_ns = 200; // half period of the reference clock
	// free running reference, phase unrelated to the system clock
	initial begin
		ref_clk_out = 1'b0;
		tx_en_out = 1'b0;
		txd_out = 4'ha;
		#7;
		forever #(half_ns) ref_clk_out = ~ref_clk_out;
	end
	// change at falling edge so setup before the rising edge holds
	task automatic put(input logic en, input logic [3:0] d);
		@(negedge ref_clk_out);
		tx_en_out = en;
		txd_out = en ? d : ~d; // released nibble shows junk
	endtask : put
endmodule : pmt_mac_model

/* test/pmt_datapath_tb.sv */
/* pmt_datapath_tb: self-checking bench for the datapath timing block.
 * Assumes shortened init counts; the bench drives the line side. */
`timescale 1ns/1ps
module pmt_datapath_tb;
	import pmt_pkg::*;
	localparam int POR_T = 200; // shortened power-on count
	localparam int TXC_T = 100; // shortened pin reset count
	logic sys_clk, rst, ce, spd, fdx, hw_rst_n, act, tx_clk, rx_dv, crs;
	logic pos, iso, rdy, ref_clk, tx_en;
	logic [3:0] rx_nib, txd, rxd;
	logic [4:0] code;
	int err_total = 0;
	int n_compared = 0;

	// far side MAC
	pmt_mac_model mac_u (.ref_clk_out(ref_clk), .tx_en_out(tx_en),
		.txd_out(txd));
	pmt_datapath #(.POR_CYC_P(21'h0000c8), .TXCLK_CYC_P(21'h000064),
		.NLP_PERIOD_CYC_P(21'h000032)) dut_u (
		.sys_clk_in(sys_clk), .rst_in(rst), .ce_in(ce),
		.speed_100_in(spd), .full_duplex_in(fdx), .hw_reset_n_in(hw_rst_n),
		.mii_ref_clk_in(ref_clk), .tx_en_in(tx_en), .txd_in(txd),
		.tx_clk_out(tx_clk), .rxd_out(rxd), .rx_dv_out(rx_dv),
		.crs_out(crs), .line_receive_pair_in(rx_nib),
		.line_receive_act_in(act), .line_transmit_pos_out(pos),
		.line_transmit_code_out(code), .isolated_out(iso),
		.ready_out(rdy));

	// 40 MHz system clock
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// compare and count
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	// wait up to lim cycles for f to equal v; n is the cycles used
	task automatic wait_for(ref logic f, input logic v, input int lim,
		output int n);
		n = 0;
		while (f !== v && n < lim) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
	endtask : wait_for

	// reset values, then ready after the init count
	task automatic t_reset;
		int n;
		chk("iso", 8'h01, {7'h0, iso});
		chk("code idle", {3'h0, CODE_IDLE}, {3'h0, code});
		chk("txclk", 8'h00, {7'h0, tx_clk});
		@(negedge sys_clk);
		rst = 1'b0;
		wait_for(rdy, 1'b1, POR_T + 20, n);
		chk("por lo", 8'h01, {7'h0, n >= POR_T});
		chk("por hi", 8'h01, {7'h0, n <= POR_T + 8});
		$display("test reset done");
	endtask : t_reset

	// receive latency from the taking edge, limit in cycles
	task automatic t_rx(input logic s, input int lim);
		int n;
		@(negedge sys_clk);
		spd = s;
		repeat (8) @(negedge sys_clk);
		act = 1'b1;
		rx_nib = 4'h5;
		wait_for(rx_dv, 1'b1, 40, n);
		chk("rx lat", 8'h01, {7'h0, n <= lim + 1});
		chk("rxd", 8'h05, {4'h0, rxd});
		@(negedge sys_clk);
		act = 1'b0;
		rx_nib = 4'ha;
		wait_for(rx_dv, 1'b0, 40, n);
		chk("rx end", 8'h00, {7'h0, rx_dv});
		$display("test rx done");
	endtask : t_rx

	// 100M framing J K data T R idle, no transmit carrier
	task automatic t_tx100;
		logic [4:0] want [6];
		want = '{CODE_J, CODE_K, CODE_4B5B[7], CODE_T, CODE_R, CODE_IDLE};
		@(negedge sys_clk);
		spd = 1'b1;
		mac_u.half_ns = 100;
		repeat (8) @(negedge sys_clk);
		for (int i = 0; i < 6; i++) begin
			if (i == 0) begin
				mac_u.put(1'b1, 4'h7);
			end else if (i == 3) begin
				mac_u.put(1'b0, 4'h7);
			end else begin
				@(negedge ref_clk);
			end
			@(posedge ref_clk);
			repeat (4) @(posedge sys_clk);
			#1;
			chk("code", {3'h0, want[i]}, {3'h0, code});
			chk("crs 100", 8'h00, {7'h0, crs});
		end
		$display("test tx100 done");
	endtask : t_tx100

	// 10M serial bits LSB first and carrier sense
	task automatic t_tx10;
		int n;
		@(negedge sys_clk);
		spd = 1'b0;
		mac_u.half_ns = 200;
		repeat (8) @(negedge sys_clk);
		mac_u.put(1'b1, 4'h5);
		wait_for(crs, 1'b1, 12, n);
		chk("crs on", 8'h01, {7'h0, n <= 2 * BIT10_CYC});
		@(posedge ref_clk);
		wait_for(pos, 1'b1, 2 + 2 * BIT10_CYC, n);
		chk("tx first", 8'h01, {7'h0, pos});
		for (int b = 1; b < 4; b++) begin
			repeat (BIT10_CYC) @(posedge sys_clk);
			#1;
			chk("tx bit", {7'h0, ~b[0]}, {7'h0, pos});
		end
		mac_u.put(1'b0, 4'h5);
		wait_for(crs, 1'b0, 20, n);
		chk("crs off", 8'h01, {7'h0, n <= 4 * BIT10_CYC});
		$display("test tx10 done");
	endtask : t_tx10

	// idle 10M link pulses on the serial pin: width and spacing
	task automatic t_nlp;
		int n;
		int w;
		repeat (20) @(negedge sys_clk);
		wait_for(pos, 1'b1, 80, n);
		wait_for(pos, 1'b0, 10, w);
		chk("nlp width", 8'h04, 8'(w));
		wait_for(pos, 1'b1, 80, n);
		chk("nlp lo", 8'h01, {7'h0, n + w >= 50});
		chk("nlp hi", 8'h01, {7'h0, n + w <= 58});
		$display("test nlp done");
	endtask : t_nlp

	// pin reset of len cycles: isolation, then re-init only if long
	task automatic t_hwrst(input int len);
		int n;
		@(negedge sys_clk);
		hw_rst_n = 1'b0;
		wait_for(iso, 1'b1, 6, n);
		chk("iso lat", 8'h01, {7'h0, n <= 3});
		repeat (len) @(negedge sys_clk);
		chk("txclk rst", 8'h00, {7'h0, tx_clk});
		hw_rst_n = 1'b1;
		wait_for(rdy, 1'b1, TXC_T + 20, n);
		if (len >= RST_MIN_CYC) begin
			chk("reinit", 8'h01, {7'h0, n >= TXC_T});
		end else begin
			chk("short", 8'h01, {7'h0, n < 10});
		end
		chk("ready", 8'h01, {7'h0, rdy});
		$display("test pin reset done");
	endtask : t_hwrst

	// verdict and end of run
	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_of_test

	// watchdog well beyond the expected run
	initial begin
		repeat (20000) @(posedge sys_clk);
		err_total++;
		end_of_test();
	end

	// main sequence
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		spd = 1'b0;
		fdx = 1'b0;
		hw_rst_n = 1'b1;
		act = 1'b0;
		rx_nib = 4'ha;
		repeat (16) @(posedge sys_clk);
		#1;
		t_reset();
		t_rx(1'b0, RX10_LAT_CYC);
		t_rx(1'b1, RX100_LAT_CYC);
		t_tx100();
		t_tx10();
		t_nlp();
		t_hwrst(12);
		t_hwrst(4);
		end_of_test();
	end
endmodule : pmt_datapath_tb
